/* File: rtl/sff_pkg.sv */
// constants, field layouts and types for the spi fifo/format/status block
package sff_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] SFF_OFS_FRAME_CFG = 8'h00;
  localparam logic [7:0] SFF_OFS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] SFF_OFS_DATA_PORT = 8'h08;
  localparam logic [7:0] SFF_OFS_FIFO_STATUS = 8'h0C;
  localparam logic [7:0] SFF_OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] SFF_OFS_IRQ_MASK = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // control_two field positions
  localparam int SFF_POS_RX_ORDER = 4;
  localparam int SFF_POS_WAIT_EN = 6;
  localparam int SFF_POS_RX_TRIG = 7;
  localparam int SFF_POS_TX_TRIG = 10;
  localparam int SFF_POS_GAP = 14;
  localparam int SFF_POS_TX_ORDER = 18;
  localparam int SFF_POS_IN_DELAY = 21;

  // frame_cfg field positions
  localparam int SFF_POS_SIZE = 0;
  localparam int SFF_POS_ENABLE = 5;
  localparam int SFF_POS_CMD_FMT = 6;

  // fifo_status bit positions
  localparam int SFF_POS_TFE = 0;
  localparam int SFF_POS_TNF = 1;
  localparam int SFF_POS_RNE = 2;
  localparam int SFF_POS_RFF = 3;
  localparam int SFF_POS_BSY = 4;

  // interrupt event bit positions
  localparam int SFF_EV_RX_TRIG = 0;
  localparam int SFF_EV_TX_TRIG = 1;
  localparam int SFF_EV_RX_OVERRUN = 2;
  localparam int SFF_EV_FRAME_DONE = 3;
  localparam int SFF_EV_COUNT = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic [4:0] SFF_RST_SIZE_M1 = 5'h07;
  localparam logic [4:0] SFF_MIN_SIZE_M1 = 5'h03;
  localparam logic [5:0] SFF_IN_DELAY_CYCLES = 6'h02;

  ////////////////////////////////////////////////////////////////////////////////
  // trigger level codes
  typedef enum logic [2:0] {
    SFF_TRIG_1 = 3'h0,
    SFF_TRIG_4 = 3'h1,
    SFF_TRIG_8 = 3'h2
  } sff_trig_t;

  // byte/bit ordering codes
  typedef enum logic [1:0] {
    SFF_ORD_MSB_MSB = 2'h0,
    SFF_ORD_LSB_MSB = 2'h1,
    SFF_ORD_MSB_LSB = 2'h2,
    SFF_ORD_LSB_LSB = 2'h3
  } sff_order_t;

  // shifter states, one-hot
  typedef enum logic [2:0] {
    SFF_IDLE = 3'b001,
    SFF_SHIFT = 3'b010,
    SFF_GAP = 3'b100
  } sff_state_t;

  // control_two contents
  typedef struct packed {
    logic in_delay;
    logic [1:0] tx_order;
    logic [3:0] gap;
    logic [2:0] tx_trig;
    logic [2:0] rx_trig;
    logic wait_en;
    logic [1:0] rx_order;
  } sff_ctrl_t;

  // frame_cfg contents
  typedef struct packed {
    logic cmd_fmt;
    logic enable;
    logic [4:0] size_m1;
  } sff_cfg_t;

endpackage

/* File: rtl/sff_top.sv */
// spi slave shifter with tx/rx fifos, ordering control and status registers
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module sff_top #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // serial link, sclk sampled as data
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  // interrupt
  output logic irq
);

  localparam int AW = $clog2(DEPTH);

  // depth below eight cannot reach the highest trigger level;
  // pointers wrap on their own only for a power of two
  if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("sff_top: DEPTH must be a power of two of at least 8");
  end

  // the whole block state is one packed struct
  typedef struct packed {
    // register port and configuration
    logic [31:0] rdata;
    sff_pkg::sff_cfg_t cfg;
    sff_pkg::sff_ctrl_t ctrl;
    // fifos as word arrays with read and write pointers
    logic [DEPTH-1:0][31:0] tx_mem;
    logic [AW-1:0] tx_rd;
    logic [AW-1:0] tx_wr;
    logic [AW:0] tx_cnt;
    logic [DEPTH-1:0][31:0] rx_mem;
    logic [AW-1:0] rx_rd;
    logic [AW-1:0] rx_wr;
    logic [AW:0] rx_cnt;
    // link synchronisers and optional input delay
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic [sff_pkg::SFF_IN_DELAY_CYCLES-1:0] mosi_d;
    // shifter
    sff_pkg::sff_state_t state;
    logic [5:0] bit_cnt;
    logic skip;
    logic [3:0] gap_cnt;
    logic [31:0] tx_sh;
    logic [31:0] rx_acc;
    logic miso;
    // interrupt status and mask
    logic [sff_pkg::SFF_EV_COUNT-1:0] irq_st;
    logic [sff_pkg::SFF_EV_COUNT-1:0] irq_mask;
  } sff_state_reg_t;

  sff_state_reg_t st_reg;
  sff_state_reg_t st_next;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // trigger code to element count; reserved codes act as one element
  function automatic logic [AW:0] sff_level(input logic [2:0] code);
    logic [AW:0] lvl;
    lvl = (AW + 1)'(1);
    if (code == sff_pkg::SFF_TRIG_4)
      lvl = (AW + 1)'(4);
    else if (code == sff_pkg::SFF_TRIG_8)
      lvl = (AW + 1)'(8);
    return lvl;
  endfunction

  // word bit that travels as the k-th bit on the wire
  function automatic logic [4:0] sff_pos(input logic [5:0] k, input logic [5:0] n,
                                         input logic [1:0] ord);
    logic [1:0] o;
    logic [5:0] byte_i;
    logic [5:0] bsel;
    logic [5:0] bit_j;
    logic [5:0] p;
    o = ord;
    byte_i = k >> 3;
    bit_j = k & 6'h07;
    bsel = 6'h00;
    // mixed orders need 16, 24 or 32 bits; other sizes fall back to plain order
    if ((o == sff_pkg::SFF_ORD_LSB_MSB || o == sff_pkg::SFF_ORD_MSB_LSB) &&
        !(n == 6'h10 || n == 6'h18 || n == 6'h20))
      o = sff_pkg::SFF_ORD_MSB_MSB;
    if (o == sff_pkg::SFF_ORD_MSB_MSB)
      p = n - 6'h01 - k;
    else if (o == sff_pkg::SFF_ORD_LSB_LSB)
      p = k;
    else
    begin
      // mixed: o[0] picks the byte order, o[1] the bit order inside a byte
      bsel = o[0] ? byte_i : (n >> 3) - 6'h01 - byte_i;
      p = {bsel[2:0], 3'h0} + (o[1] ? bit_j : 6'h07 - bit_j);
    end
    return p[4:0];
  endfunction

  // reorders a word so the wire bits leave from bit 31 downward
  function automatic logic [31:0] sff_tx_seq(input logic [31:0] word, input logic [5:0] n,
                                             input logic [1:0] ord);
    logic [31:0] seq;
    seq = 32'h0000_0000;
    // only the low n bits are looked at, upper bits are ignored
    for (int k = 0; k < 32; k++)
    begin
      if (6'(k) < n)
        seq[31-k] = word[sff_pos(6'(k), n, ord)];
    end
    return seq;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    // per-cycle strobes and scratch values
    logic [5:0] n;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic rise;
    logic fall;
    logic cs_act;
    logic din;
    logic reload;
    logic [31:0] acc;
    logic [sff_pkg::SFF_EV_COUNT-1:0] ev;
    logic irq_clr;
    n = {1'b0, st_reg.cfg.size_m1} + 6'h01;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    reload = 1'b0;
    acc = st_reg.rx_acc;
    ev = '0;
    irq_clr = 1'b0;
    // every register holds unless a branch below moves it
    st_next = st_reg;

    // link synchronisers; first flops feed only the second ones
    st_next.sclk_s = {st_reg.sclk_s[1:0], sclk};
    st_next.cs_s = {st_reg.cs_s[0], cs_n};
    st_next.mosi_s = {st_reg.mosi_s[0], mosi};
    st_next.mosi_d = {st_reg.mosi_d[sff_pkg::SFF_IN_DELAY_CYCLES-2:0], st_reg.mosi_s[1]};
    // edges come from the second and third sclk flops, never the first
    rise = st_reg.sclk_s[1] && !st_reg.sclk_s[2];
    fall = !st_reg.sclk_s[1] && st_reg.sclk_s[2];
    cs_act = !st_reg.cs_s[1] && st_reg.cfg.enable;
    // optional two-cycle delay on the data input
    din = st_reg.ctrl.in_delay ? st_reg.mosi_d[sff_pkg::SFF_IN_DELAY_CYCLES-1] :
          st_reg.mosi_s[1];

    // register port; a read answers in the next cycle
    st_next.rdata = 32'h0000_0000;
    if (wr)
    begin
      if (addr == sff_pkg::SFF_OFS_FRAME_CFG)
      begin
        // frame size, enable and command format share one word
        st_next.cfg = wdata[sff_pkg::SFF_POS_CMD_FMT:0];
        if (wdata[4:0] < sff_pkg::SFF_MIN_SIZE_M1)
          st_next.cfg.size_m1 = sff_pkg::SFF_MIN_SIZE_M1; // sizes below 4 are clamped
      end
      else if (addr == sff_pkg::SFF_OFS_CONTROL_TWO)
      begin
        // reserved bits are not stored and read back as zero
        st_next.ctrl.rx_order = wdata[sff_pkg::SFF_POS_RX_ORDER +: 2];
        st_next.ctrl.wait_en = wdata[sff_pkg::SFF_POS_WAIT_EN];
        st_next.ctrl.rx_trig = wdata[sff_pkg::SFF_POS_RX_TRIG +: 3];
        st_next.ctrl.tx_trig = wdata[sff_pkg::SFF_POS_TX_TRIG +: 3];
        st_next.ctrl.gap = wdata[sff_pkg::SFF_POS_GAP +: 4];
        st_next.ctrl.tx_order = wdata[sff_pkg::SFF_POS_TX_ORDER +: 2];
        st_next.ctrl.in_delay = wdata[sff_pkg::SFF_POS_IN_DELAY];
      end
      else if (addr == sff_pkg::SFF_OFS_DATA_PORT)
        tx_push = (st_reg.tx_cnt != (AW + 1)'(DEPTH)); // full fifo drops the word
      else if (addr == sff_pkg::SFF_OFS_IRQ_MASK)
        st_next.irq_mask = wdata[sff_pkg::SFF_EV_COUNT-1:0];
      // fifo_status and irq_status writes fall through untouched
    end
    // read decode; a word not addressed or not mapped reads zero
    if (rd)
    begin
      if (addr == sff_pkg::SFF_OFS_FRAME_CFG)
        st_next.rdata = {25'h0, st_reg.cfg};
      else if (addr == sff_pkg::SFF_OFS_CONTROL_TWO)
      begin
        st_next.rdata[sff_pkg::SFF_POS_RX_ORDER +: 2] = st_reg.ctrl.rx_order;
        st_next.rdata[sff_pkg::SFF_POS_WAIT_EN] = st_reg.ctrl.wait_en;
        st_next.rdata[sff_pkg::SFF_POS_RX_TRIG +: 3] = st_reg.ctrl.rx_trig;
        st_next.rdata[sff_pkg::SFF_POS_TX_TRIG +: 3] = st_reg.ctrl.tx_trig;
        st_next.rdata[sff_pkg::SFF_POS_GAP +: 4] = st_reg.ctrl.gap;
        st_next.rdata[sff_pkg::SFF_POS_TX_ORDER +: 2] = st_reg.ctrl.tx_order;
        st_next.rdata[sff_pkg::SFF_POS_IN_DELAY] = st_reg.ctrl.in_delay;
      end
      else if (addr == sff_pkg::SFF_OFS_DATA_PORT)
      begin
        rx_pop = (st_reg.rx_cnt != '0);
        if (rx_pop)
          st_next.rdata = st_reg.rx_mem[st_reg.rx_rd];
      end
      else if (addr == sff_pkg::SFF_OFS_FIFO_STATUS)
      begin
        // flags come straight from the counters and the shifter state, so they never go stale
        st_next.rdata[sff_pkg::SFF_POS_TFE] = (st_reg.tx_cnt == '0);
        st_next.rdata[sff_pkg::SFF_POS_TNF] = (st_reg.tx_cnt != (AW + 1)'(DEPTH));
        st_next.rdata[sff_pkg::SFF_POS_RNE] = (st_reg.rx_cnt != '0);
        st_next.rdata[sff_pkg::SFF_POS_RFF] = (st_reg.rx_cnt == (AW + 1)'(DEPTH));
        st_next.rdata[sff_pkg::SFF_POS_BSY] = (st_reg.state != sff_pkg::SFF_IDLE) ||
                                              (st_reg.tx_cnt != '0);
      end
      else if (addr == sff_pkg::SFF_OFS_IRQ_STATUS)
      begin
        st_next.rdata = {28'h0, st_reg.irq_st};
        irq_clr = 1'b1;
      end
      else if (addr == sff_pkg::SFF_OFS_IRQ_MASK)
        st_next.rdata = {28'h0, st_reg.irq_mask};
    end

    // shifter: mode 0 slave, sample on rising sclk, drive on falling
    case (st_reg.state)
      sff_pkg::SFF_IDLE:
      begin
        if (cs_act)
        begin
          // select seen: pop the head word and show its first bit at once
          tx_pop = (st_reg.tx_cnt != '0);
          st_next.tx_sh = tx_pop ? sff_tx_seq(st_reg.tx_mem[st_reg.tx_rd], n,
                                              st_reg.ctrl.tx_order) : 32'h0000_0000;
          st_next.miso = st_next.tx_sh[31];
          st_next.tx_sh = {st_next.tx_sh[30:0], 1'b0};
          st_next.bit_cnt = 6'h00;
          st_next.rx_acc = 32'h0000_0000;
          st_next.skip = st_reg.cfg.cmd_fmt && st_reg.ctrl.wait_en;
          st_next.state = sff_pkg::SFF_SHIFT;
        end
      end
      sff_pkg::SFF_SHIFT:
      begin
        if (!cs_act)
          st_next.state = sff_pkg::SFF_IDLE; // frame cut short, partial word dropped
        else if (rise)
        begin
          // sample on the rising edge; the falling edge moves the output
          if (st_reg.skip)
            st_next.skip = 1'b0; // one wait clock in command format
          else
          begin
            acc[sff_pos(st_reg.bit_cnt, n, st_reg.ctrl.rx_order)] = din;
            st_next.rx_acc = acc;
            st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
            if (st_reg.bit_cnt == n - 6'h01)
            begin
              // last bit: push the word; a full rx fifo loses it as an overrun
              ev[sff_pkg::SFF_EV_FRAME_DONE] = 1'b1;
              rx_push = (st_reg.rx_cnt != (AW + 1)'(DEPTH));
              ev[sff_pkg::SFF_EV_RX_OVERRUN] = !rx_push;
              if (!st_reg.cfg.cmd_fmt && st_reg.ctrl.gap != 4'h0)
              begin
                st_next.gap_cnt = st_reg.ctrl.gap;
                st_next.state = sff_pkg::SFF_GAP;
              end
              else
                reload = 1'b1;
            end
          end
        end
        else if (fall)
        begin
          st_next.miso = st_reg.tx_sh[31];
          st_next.tx_sh = {st_reg.tx_sh[30:0], 1'b0};
        end
      end
      sff_pkg::SFF_GAP:
      begin
        // gap counts sclk periods during which nothing is shifted
        // a select released in the gap ends it like a cut frame
        if (!cs_act)
          st_next.state = sff_pkg::SFF_IDLE;
        else if (rise)
        begin
          st_next.gap_cnt = st_reg.gap_cnt - 4'h1;
          if (st_reg.gap_cnt == 4'h1)
          begin
            reload = 1'b1;
            st_next.state = sff_pkg::SFF_SHIFT;
          end
        end
      end
      // an illegal state code falls back to idle
      default:
        st_next.state = sff_pkg::SFF_IDLE;
    endcase

    // back-to-back frame: the next falling edge shows the first bit
    // an empty tx fifo sends zeros; no underrun is flagged here
    if (reload)
    begin
      tx_pop = (st_reg.tx_cnt != '0);
      st_next.tx_sh = tx_pop ? sff_tx_seq(st_reg.tx_mem[st_reg.tx_rd], n,
                                          st_reg.ctrl.tx_order) : 32'h0000_0000;
      st_next.bit_cnt = 6'h00;
      st_next.rx_acc = 32'h0000_0000;
    end

    // fifo bookkeeping
    // tx side: push from the register port, pop at frame start
    if (tx_push)
    begin
      st_next.tx_mem[st_reg.tx_wr] = wdata;
      st_next.tx_wr = st_reg.tx_wr + AW'(1);
    end
    if (tx_pop)
      st_next.tx_rd = st_reg.tx_rd + AW'(1);
    st_next.tx_cnt = st_reg.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
    // rx side: push at frame end, pop on a data read
    if (rx_push)
    begin
      st_next.rx_mem[st_reg.rx_wr] = acc;
      st_next.rx_wr = st_reg.rx_wr + AW'(1);
    end
    if (rx_pop)
      st_next.rx_rd = st_reg.rx_rd + AW'(1);
    st_next.rx_cnt = st_reg.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);

    // trigger conditions, then sticky status; a new event beats the read clear
    // b0 and b1 are levels, so a read clear only holds once the fifo drops
    ev[sff_pkg::SFF_EV_RX_TRIG] = (st_reg.rx_cnt >= sff_level(st_reg.ctrl.rx_trig));
    ev[sff_pkg::SFF_EV_TX_TRIG] = (st_reg.tx_cnt >= sff_level(st_reg.ctrl.tx_trig));
    st_next.irq_st = (irq_clr ? '0 : st_reg.irq_st) | ev;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // synchronisers start at the idle pin levels: sclk low, select high
      st_reg <= '0;
      st_reg.cfg.size_m1 <= sff_pkg::SFF_RST_SIZE_M1;
      st_reg.state <= sff_pkg::SFF_IDLE;
      st_reg.sclk_s <= 3'h0;
      st_reg.cs_s <= 2'h3;
    end
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  // read data stand for one cycle only, zero otherwise
  assign rdata = st_reg.rdata;
  // serial output comes straight from its flop
  assign miso_o = st_reg.miso;
  // drive only while selected and enabled, so other slaves can share the line
  assign miso_oe = !st_reg.cs_s[1] && st_reg.cfg.enable;
  // level interrupt from the masked sticky bits
  assign irq = |(st_reg.irq_st & st_reg.irq_mask);

endmodule

/* File: sim/sff_master_model.sv */
// mode 0 spi master standing at the link side
`timescale 1ns/1ps
module sff_master (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // idle link: clock low, deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one select window of n clocks, first bit from dout[n-1]
  task automatic xfer(input int n, input logic [63:0] dout, output logic [63:0] din);
    din = '0;
    #3 cs_n = 1'b0; // offset keeps link edges off mclk edges
    #200;
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi = dout[i];
      #100 sclk = 1'b1;
      din[i] = miso;
      #100 sclk = 1'b0;
    end
    #200 cs_n = 1'b1;
    mosi = ~mosi; // released line must not show a stale bit
    #200;
  endtask
endmodule

/* File: sim/sff_top_asserts.sv */
// register port checks for the fifo/format/status block
`timescale 1ns/1ps
module sff_chk #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // interrupt
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // status read decode
  wire logic st_rd = rd && addr == 8'h0C;
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_status_resv: assert property (st_rd |=> rdata[31:5] == 27'h0)
    else $error("status reserved bits set");
  a_tx_flags: assert property (st_rd |=> !rdata[0] || rdata[1])
    else $error("tx empty without space");
  a_rx_flags: assert property (st_rd |=> !rdata[3] || rdata[2])
    else $error("rx full without data");
  a_busy_tx: assert property (st_rd |=> rdata[0] || rdata[4])
    else $error("busy low with tx data held");
  a_push_seen: assert property (wr && addr == 8'h08 ##2 st_rd |=> !rdata[0])
    else $error("data write did not leave tx non-empty");
  a_mask_off: assert property (wr && addr == 8'h14 && wdata == 32'h0 |=> !irq)
    else $error("irq high with all masked");
  a_unmapped: assert property (rd && addr > 8'h14 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind sff_top sff_chk #(.DEPTH(DEPTH)) u_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

/* File: sim/sff_top_tb_top.sv */
// self-checking bench for the fifo/format/status block
`timescale 1ns/1ps
module sff_top_tb_top;
  logic mclk, rst_n, wr, rd, sclk, cs_n, mosi, miso_o, miso_oe, irq;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [63:0] din;
  int err_count;
  int check_count;
  wire logic miso = miso_oe ? miso_o : 1'bz;
  sff_top #(.DEPTH(8)) u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .irq(irq));
  sff_master u_far (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // 40 MHz block clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bus tasks start right after an edge and end on one
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string w);
    logic [31:0] v;
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(w, v, exp);
    @(posedge mclk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // value bit sent at wire position i; mixed codes fall back to 00 off 16/24/32
  function automatic int src_of(int i, int n, logic [1:0] o);
    if (o == 2'h1 && n % 8 == 0 && n >= 16) return (i / 8) * 8 + 7 - i % 8;
    if (o == 2'h2 && n % 8 == 0 && n >= 16) return (n / 8 - 1 - i / 8) * 8 + i % 8;
    if (o == 2'h3) return i;
    return n - 1 - i;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(8'h0C, 32'h3, "status at reset");
    rc(8'h08, 32'h0, "empty data read");
    wr_reg(8'h0C, 32'h0);
    rc(8'h0C, 32'h3, "status after write");
    wr_reg(8'h08, 32'h7);
    rc(8'h0C, 32'h12, "status one queued");
    rc(8'h20, 32'h0, "unmapped read");
  endtask
  // tx trigger per code; reserved code behaves as one element
  task automatic t_trig();
    // deepest level last, so the fifo is left full for the status check
    int code [4] = '{0, 1, 3, 2};
    int lvl [4] = '{1, 4, 1, 8};
    for (int c = 0; c < 4; c++)
    begin
      do_reset();
      wr_reg(8'h04, 32'(code[c]) << 10);
      wr_reg(8'h14, 32'h2);
      for (int i = 1; i < lvl[c]; i++)
        wr_reg(8'h08, 32'(i));
      #1 chk("irq below level", {31'h0, irq}, 32'h0);
      wr_reg(8'h08, 32'h55);
      #1 chk("irq at level", {31'h0, irq}, 32'h1);
    end
    rc(8'h0C, 32'h10, "tx full status");
    rc(8'h10, 32'h2, "tx event");
    wr_reg(8'h14, 32'h0);
  endtask
  // all order codes at edge and byte-multiple sizes, upper junk bits written
  task automatic t_order();
    int sz [4] = '{4, 16, 24, 32};
    int n, k;
    logic [31:0] txv, snt, etx, erx;
    for (int o = 0; o < 4; o++)
      for (int s = 0; s < 4; s++)
      begin
        n = sz[s];
        txv = 32'hA5C35A96 + 32'(o * 7 + s);
        snt = 32'h3C96E1D5 ^ txv;
        snt = (n == 32) ? snt : snt & ((32'h1 << n) - 32'h1);
        etx = '0;
        erx = '0;
        for (int i = 0; i < n; i++)
        begin
          k = src_of(i, n, 2'(o));
          etx[n - 1 - i] = txv[k];
          erx[k] = snt[n - 1 - i];
        end
        wr_reg(8'h00, {25'h0, 2'b01, 5'(n - 1)});
        wr_reg(8'h04, (32'(o) << 18) | (32'(o) << 4) | (32'(s == 3) << 21));
        rc(8'h04, (32'(o) << 18) | (32'(o) << 4) | (32'(s == 3) << 21), "ctrl");
        wr_reg(8'h08, txv);
        u_far.xfer(n, {32'h0, snt}, din);
        @(posedge mclk);
        chk("tx wire bits", din[31:0], etx);
        rc(8'h08, erx, "rx word");
      end
  endtask
  // rx trigger at four, rx fifo filled and drained in order
  task automatic t_rx();
    rc(8'h10, 32'hB, "events after frames");
    wr_reg(8'h00, 32'h27);
    wr_reg(8'h04, 32'h1 << 7);
    wr_reg(8'h14, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      #1 chk("rx irq", {31'h0, irq}, 32'(i >= 4));
      u_far.xfer(8, 64'(i + 8'hA0), din);
      @(posedge mclk);
    end
    rc(8'h0C, 32'hF, "rx full status");
    for (int i = 0; i < 8; i++)
      rc(8'h08, 32'(i + 8'hA0), "rx pop");
    rc(8'h10, 32'h9, "rx events");
    #1 chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  // idle clocks between back-to-back frames, then command-format wait
  task automatic t_gap_cmd();
    wr_reg(8'h04, 32'h2 << 14);
    wr_reg(8'h08, 32'h5A);
    wr_reg(8'h08, 32'hC3);
    u_far.xfer(18, 64'h25B3C, din);
    @(posedge mclk);
    chk("gap tx", {16'h0, din[17:10], din[7:0]}, 32'h5AC3);
    rc(8'h08, 32'h96, "gap rx first");
    rc(8'h08, 32'h3C, "gap rx second");
    wr_reg(8'h00, 32'h67);
    wr_reg(8'h04, 32'h40);
    u_far.xfer(9, 64'h13C, din);
    @(posedge mclk);
    rc(8'h08, 32'h3C, "wait state rx");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    err_count = 0;
    check_count = 0;
    do_reset();
    t_reset();
    t_trig();
    do_reset();
    t_order();
    t_rx();
    t_gap_cmd();
    end_sim();
  end
  // whole-run limit against a hang
  initial
  begin
    #1000000;
    err_count++;
    end_sim();
  end
endmodule
